// file: inc/inhibit_fault_params.svh
`ifndef INHIBIT_FAULT_PARAMS_SVH
`define INHIBIT_FAULT_PARAMS_SVH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_CLEAR 8'h04
`define REG_GPIO 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_MASK 8'h14
// Control field positions
`define CTRL_FUNC_BIT 0
`define CTRL_RI_LO 1
`define CTRL_FLT_EN_BIT 3
`define CTRL_SRC_LO 4
`define CTRL_OUT_ON_BIT 6
`define CTRL_WIDTH 7
// Clear register field
`define CLEAR_PROT_BIT 0
// Reset values
`define CTRL_RESET 7'h00
`define GPIO_RESET 3'h0
`define IRQ_MASK_RESET 5'h00
// Protection flag indices
`define PROT_RI 0
`define PROT_OV 1
`define PROT_OC 2
`define PROT_OT 3
`define PROT_FS 4
`define PROT_COUNT 5
`endif

// file: inc/inhibit_fault_pkg.sv
package inhibit_fault_pkg;
	// Port function
	typedef enum logic {
		inhibit_fault_mode,
		general_io_mode
	} port_function_e;
	// Remote inhibit configuration
	typedef enum logic [1:0] {
		inhibit_off,
		inhibit_tracking,
		inhibit_latching,
		inhibit_spare
	} remote_inhibit_config_e;
	// Fault output source
	typedef enum logic [1:0] {
		src_service_request,
		src_event_summary,
		src_operation,
		src_questionable
	} fault_source_select_e;
	// Status summaries from the status subsystem
	typedef struct packed {
		logic service_request_bit;
		logic event_summary_bit;
		logic operation_summary;
		logic questionable_summary;
	} summary_s;
	// Raw protection causes from the power stage
	typedef struct packed {
		logic fuse_open;
		logic over_temp;
		logic over_current;
		logic over_voltage;
	} prot_cause_s;
	// Control register
	typedef struct packed {
		logic output_on;
		fault_source_select_e fault_source_select;
		logic fault_indicator_enable;
		remote_inhibit_config_e remote_inhibit_config;
		port_function_e port_function;
	} ctrl_s;
endpackage

// file: hdl/inhibit_fault_digital_port.sv
// Operation
// - Reset starts in inhibit plus fault mode
// - Function setting picks exactly one function
// - Tracking or latching choice enables inhibit
// - Low inhibit input turns output off
// - Tracking: output follows inhibit input level
// - Latching: output stays off after release
// - Fault pin inactive unless indicator enabled
// - Fault pin open-collector, asserts while the selected summary is high
// - Source select picks one of four summaries
// - Write 0..7 programs the port bits
// - Port read returns present pin state
// - Faults disable output, distinct indicators each
// - Protection clear restores output once cause gone
`timescale 1ns/1ps
`include "inhibit_fault_params.svh"
module inhibit_fault_digital_port
	import inhibit_fault_pkg::*;
#(
	parameter int IO_BITS = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Inhibit pin, low true, asynchronous
	input wire logic inhibit_input_n,
	// Fault pin, open collector
	input wire logic fault_output_i,
	output logic fault_output_o,
	output logic fault_output_oe,
	// General purpose port pins
	input wire logic [IO_BITS-1:0] gpio_i,
	output logic [IO_BITS-1:0] gpio_o,
	output logic [IO_BITS-1:0] gpio_oe,
	// Status and power stage
	input wire summary_s summary,
	input wire prot_cause_s prot_cause,
	output logic output_enable,
	output logic irq
);
	// Synchroniser stages, first stage read by the second and by the inhibit_off_a check
	logic inh_s1_ff, inh_s2_ff, flt_s1_ff, flt_s2_ff;
	logic [IO_BITS-1:0] gp_s1_ff, gp_s2_ff;
	// Software state
	ctrl_s ctrl_ff, nxt_ctrl;
	logic [IO_BITS-1:0] gpio_val_ff, nxt_gpio_val;
	logic [`PROT_COUNT-1:0] irq_stat_ff, nxt_irq_stat, irq_mask_ff, nxt_irq_mask;
	// Protection state
	logic [`PROT_COUNT-1:0] prot_ff, nxt_prot;
	logic latch_ff, nxt_latch;
	logic out_en_ff, nxt_out_en;
	logic flt_oe_ff, nxt_flt_oe;
	logic [IO_BITS-1:0] gpio_oe_ff, nxt_gpio_oe;
	logic irq_ff, nxt_irq;
	// Bus answer state
	logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic [31:0] prdata_ff, nxt_prdata;
	// Decoded helpers
	logic wr_acc, rd_acc, clear_cmd, inh_act, trk_act, sel_sum;
	logic [`PROT_COUNT-1:0] causes;

	// Map address to a known register
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == `REG_CTRL) || (a == `REG_CLEAR) || (a == `REG_GPIO) ||
			(a == `REG_STATUS) || (a == `REG_IRQ_STAT) || (a == `REG_IRQ_MASK);
	endfunction

	// Two flops on every pin input
	always_ff @(posedge clk) begin
		if (rst) begin
			inh_s1_ff <= 1'b1;
			inh_s2_ff <= 1'b1;
			flt_s1_ff <= 1'b1;
			flt_s2_ff <= 1'b1;
			gp_s1_ff <= '0;
			gp_s2_ff <= '0;
		end else begin
			inh_s1_ff <= inhibit_input_n;
			inh_s2_ff <= inh_s1_ff;
			flt_s1_ff <= fault_output_i;
			flt_s2_ff <= flt_s1_ff;
			gp_s1_ff <= gpio_i;
			gp_s2_ff <= gp_s1_ff;
		end
	end

	// Bus phase decode; one wait state gives time to form read data
	assign wr_acc = psel && penable && pready_ff && pwrite;
	assign rd_acc = psel && penable && !pready_ff && !pwrite;
	assign clear_cmd = wr_acc && (paddr == `REG_CLEAR) && pwdata[`CLEAR_PROT_BIT];

	// Inhibit acts only in inhibit mode with a choice made
	always_comb begin
		inh_act = (ctrl_ff.port_function == inhibit_fault_mode) &&
			(ctrl_ff.remote_inhibit_config inside {inhibit_tracking, inhibit_latching}) &&
			!inh_s2_ff;
		trk_act = inh_act && (ctrl_ff.remote_inhibit_config == inhibit_tracking);
		causes = {prot_cause.fuse_open, prot_cause.over_temp, prot_cause.over_current,
			prot_cause.over_voltage, inh_act};
		case (ctrl_ff.fault_source_select)
			src_service_request: sel_sum = summary.service_request_bit;
			src_event_summary: sel_sum = summary.event_summary_bit;
			src_operation: sel_sum = summary.operation_summary;
			default: sel_sum = summary.questionable_summary;
		endcase
	end

	// Next values of the software registers
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_gpio_val = gpio_val_ff;
		nxt_irq_mask = irq_mask_ff;
		if (wr_acc) begin
			if (paddr == `REG_CTRL) begin
				nxt_ctrl = ctrl_s'(pwdata[`CTRL_WIDTH-1:0]);
			end else if (paddr == `REG_GPIO) begin
				nxt_gpio_val = pwdata[IO_BITS-1:0];
			end else if (paddr == `REG_IRQ_MASK) begin
				nxt_irq_mask = pwdata[`PROT_COUNT-1:0];
			end
		end
	end

	// Protection flags, latch and output enable
	always_comb begin
		// Flag per cause; the clear only takes flags whose cause is gone, and a cause wins
		nxt_prot = prot_ff;
		for (int i = 0; i < `PROT_COUNT; i++) begin
			if (causes[i]) begin
				nxt_prot[i] = 1'b1;
			end else if (clear_cmd) begin
				nxt_prot[i] = 1'b0;
			end
		end
		// Tracking indicator drops by itself when the input returns high
		if (!inh_act && !latch_ff && ctrl_ff.remote_inhibit_config != inhibit_latching) begin
			nxt_prot[`PROT_RI] = 1'b0;
		end
		// Latch survives function change; only the clear releases it
		nxt_latch = latch_ff;
		if (inh_act && ctrl_ff.remote_inhibit_config == inhibit_latching) begin
			nxt_latch = 1'b1;
		end else if (clear_cmd && !inh_act) begin
			nxt_latch = 1'b0;
		end
		nxt_out_en = ctrl_ff.output_on && !(|causes) && !(|prot_ff[`PROT_FS:`PROT_OV]) &&
			!latch_ff && !trk_act;
	end

	// Pin drive and interrupt
	always_comb begin
		// Open collector: enable pulls low, never drives high
		nxt_flt_oe = ctrl_ff.fault_indicator_enable && (ctrl_ff.port_function == inhibit_fault_mode) &&
			sel_sum;
		nxt_gpio_oe = (ctrl_ff.port_function == general_io_mode) ? {IO_BITS{1'b1}} : '0;
		// Sticky status; a new event beats a write-one clear
		nxt_irq_stat = irq_stat_ff;
		if (wr_acc && paddr == `REG_IRQ_STAT) begin
			nxt_irq_stat = irq_stat_ff & ~pwdata[`PROT_COUNT-1:0];
		end
		nxt_irq_stat = nxt_irq_stat | (nxt_prot & ~prot_ff);
		nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
	end

	// Read data and bus answer
	always_comb begin
		nxt_pready = psel && penable && !pready_ff;
		nxt_pslverr = 1'b0;
		nxt_prdata = prdata_ff;
		if (psel && penable && !pready_ff && !addr_ok(paddr)) begin
			nxt_pslverr = 1'b1;
		end
		if (rd_acc) begin
			nxt_prdata = 32'h00000000;
			if (paddr == `REG_CTRL) begin
				nxt_prdata[`CTRL_WIDTH-1:0] = ctrl_ff;
			end else if (paddr == `REG_GPIO) begin
				nxt_prdata[IO_BITS-1:0] = gp_s2_ff;
			end else if (paddr == `REG_STATUS) begin
				nxt_prdata[8:0] = {inh_s2_ff, flt_s2_ff, prot_ff, latch_ff, out_en_ff};
			end else if (paddr == `REG_IRQ_STAT) begin
				nxt_prdata[`PROT_COUNT-1:0] = irq_stat_ff;
			end else if (paddr == `REG_IRQ_MASK) begin
				nxt_prdata[`PROT_COUNT-1:0] = irq_mask_ff;
			end
		end
	end

	// Register every group
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= ctrl_s'(`CTRL_RESET);
			gpio_val_ff <= `GPIO_RESET;
			irq_mask_ff <= `IRQ_MASK_RESET;
			irq_stat_ff <= '0;
			prot_ff <= '0;
			latch_ff <= 1'b0;
			out_en_ff <= 1'b0;
			flt_oe_ff <= 1'b0;
			gpio_oe_ff <= '0;
			irq_ff <= 1'b0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			ctrl_ff <= nxt_ctrl;
			gpio_val_ff <= nxt_gpio_val;
			irq_mask_ff <= nxt_irq_mask;
			irq_stat_ff <= nxt_irq_stat;
			prot_ff <= nxt_prot;
			latch_ff <= nxt_latch;
			out_en_ff <= nxt_out_en;
			flt_oe_ff <= nxt_flt_oe;
			gpio_oe_ff <= nxt_gpio_oe;
			irq_ff <= nxt_irq;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
		end
	end

	// Outputs straight from flops; fault pin data is always low
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign fault_output_o = 1'b0;
	assign fault_output_oe = flt_oe_ff;
	assign gpio_o = gpio_val_ff;
	assign gpio_oe = gpio_oe_ff;
	assign output_enable = out_en_ff;
	assign irq = irq_ff;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence apb_setup_s;
		psel && !penable;
	endsequence
	sequence gio_write_s;
		wr_acc && paddr == `REG_GPIO && ctrl_ff.port_function == general_io_mode;
	endsequence

	reset_mode_a: assert property (disable iff (1'b0)
		rst |=> ctrl_ff.port_function == inhibit_fault_mode && !fault_output_oe)
		else $error("port not in inhibit mode after reset");
	one_function_a: assert property (
		ctrl_ff.port_function == general_io_mode |=> !fault_output_oe && gpio_oe == {IO_BITS{1'b1}})
		else $error("both port functions active");
	inhibit_mode_a: assert property (
		ctrl_ff.port_function == inhibit_fault_mode |=> gpio_oe == '0)
		else $error("port pins driven in inhibit mode");
	// Spare choice code counts as off, so only the two real choices may arm the check
	inhibit_off_a: assert property (
		$fell(inh_s1_ff) && ctrl_ff.remote_inhibit_config inside {inhibit_tracking, inhibit_latching} &&
		ctrl_ff.port_function == inhibit_fault_mode && $stable(ctrl_ff) ##1 $stable(ctrl_ff) |=> !output_enable)
		else $error("inhibit input did not disable output");
	ri_ignored_a: assert property (
		ctrl_ff.remote_inhibit_config inside {inhibit_off, inhibit_spare} && ctrl_ff.output_on && !latch_ff &&
		prot_ff[`PROT_FS:`PROT_OV] == '0 && prot_cause == '0 |=> output_enable)
		else $error("inhibit acted while not chosen");
	track_follow_a: assert property (trk_act |=> !output_enable ##0 prot_ff[`PROT_RI])
		else $error("tracking inhibit not followed");
	latch_hold_a: assert property (latch_ff && !clear_cmd |=> latch_ff && !output_enable)
		else $error("inhibit latch released without clear");
	fault_gate_a: assert property (!ctrl_ff.fault_indicator_enable |=> !fault_output_oe && !fault_output_o)
		else $error("fault pin active while disabled");
	// Source zero is the top summary bit; indexed here so a wrong mux cannot hide
	fault_src_a: assert property (
		ctrl_ff.fault_indicator_enable && ctrl_ff.port_function == inhibit_fault_mode && $stable(ctrl_ff)
		|=> fault_output_oe == $past(summary[2'd3 - ctrl_ff.fault_source_select]))
		else $error("fault pin not following selected source");
	gio_write_a: assert property (
		gio_write_s |=> gpio_o == $past(pwdata[IO_BITS-1:0]) ##1 gpio_oe == {IO_BITS{1'b1}})
		else $error("port bits not programmed");
	gio_read_a: assert property (
		apb_setup_s ##1 (rd_acc && paddr == `REG_GPIO) |=> pready && prdata[IO_BITS-1:0] == $past(gp_s2_ff))
		else $error("port read not pin state");
	prot_off_a: assert property ((|prot_cause) |=> !output_enable ##0 (|prot_ff[`PROT_FS:`PROT_OV]))
		else $error("fault did not disable output");
	prot_clear_a: assert property (clear_cmd && !(|causes) |=> prot_ff == '0 && !latch_ff)
		else $error("protection clear failed");
	// Bus answer timing, exactly one wait state
	apb_answer_a: assert property (apb_setup_s ##1 penable |-> !pready ##1 pready)
		else $error("bus answer late");
	apb_refuse_a: assert property (
		apb_setup_s ##1 (penable && !addr_ok(paddr)) |=> pready && pslverr && (pwrite || prdata == '0))
		else $error("unmapped access not refused");
	// Interrupt status and level
	irq_level_a: assert property (irq == |(irq_stat_ff & irq_mask_ff))
		else $error("interrupt level wrong");
	stat_sticky_a: assert property (
		!(wr_acc && paddr == `REG_IRQ_STAT) |=> (irq_stat_ff & $past(irq_stat_ff)) == $past(irq_stat_ff))
		else $error("event status bit lost");
	prot_event_a: assert property ((prot_ff & ~$past(prot_ff) & ~irq_stat_ff) == '0)
		else $error("protection event not recorded");
endmodule

// file: dv/ext_equipment.sv
`timescale 1ns/1ps
module ext_equipment
	import inhibit_fault_pkg::*;
(
	// Clock
	input wire logic clk,
	// Bench request to inhibit the supply
	input wire logic inhibit_req,
	// Device pins
	output logic inhibit_input_n,
	input wire logic fault_output_o,
	input wire logic fault_output_oe,
	output logic fault_output_i,
	input wire logic [2:0] gpio_o,
	input wire logic [2:0] gpio_oe,
	output logic [2:0] gpio_i
);
	// Noise on undriven port bits, so a stale value never passes
	logic [2:0] float_ff = 3'h5;
	// Pattern steps every cycle
	always @(posedge clk) begin
		float_ff <= float_ff + 3'h3;
	end
	// Equipment pulls inhibit low to disable the supply
	assign inhibit_input_n = ~inhibit_req;
	// Pull-up on the fault wire; low only while the device sinks it
	assign fault_output_i = fault_output_oe ? fault_output_o : 1'b1;
	// Driven bits show the device value, the rest float
	assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & float_ff);
endmodule

// file: dv/test_inhibit_fault_digital_port.sv
`timescale 1ns/1ps
`include "inhibit_fault_params.svh"
module test_inhibit_fault_digital_port;
	import inhibit_fault_pkg::*;
	// Clock, reset and bus master state
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, inhibit_n, fault_i, fault_o, fault_oe, output_enable, irq;
	// Far side and status inputs
	logic inhibit_req = 1'b0;
	logic [2:0] gpio_i, gpio_o, gpio_oe;
	summary_s summary = '0;
	prot_cause_s prot_cause = '0;
	// Expected read answers, {pslverr, prdata}
	logic [32:0] expect_q[$];
	int bad_count = 0, num_checks = 0;
	logic [2:0] val;
	always #2.5 clk = ~clk;
	inhibit_fault_digital_port dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .inhibit_input_n(inhibit_n), .fault_output_i(fault_i),
		.fault_output_o(fault_o), .fault_output_oe(fault_oe), .gpio_i(gpio_i), .gpio_o(gpio_o),
		.gpio_oe(gpio_oe), .summary(summary), .prot_cause(prot_cause),
		.output_enable(output_enable), .irq(irq));
	ext_equipment equip (.clk(clk), .inhibit_req(inhibit_req), .inhibit_input_n(inhibit_n),
		.fault_output_o(fault_o), .fault_output_oe(fault_oe), .fault_output_i(fault_i),
		.gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_i(gpio_i));
	// Single comparison point
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// Read notes its expectation before the bus sees it
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expect_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	// Monitor takes the oldest note whenever read data is valid
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && expect_q.size() > 0) begin
			check({pslverr, prdata}, expect_q.pop_front());
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		repeat (6000) @(posedge clk);
		bad_count++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'h0C11));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(`REG_CTRL, 33'h0);
		rd(`REG_STATUS, 33'h180);
		rd(8'h18, 33'h100000000);
		check(33'(gpio_oe), 33'h0);
		// Tracking inhibit: output follows the pin
		wr(`REG_CTRL, 32'h42);
		idle(3);
		check(33'(output_enable), 33'h1);
		inhibit_req <= 1'b1;
		idle(8);
		check(33'(output_enable), 33'h0);
		rd(`REG_STATUS, 33'h084);
		inhibit_req <= 1'b0;
		idle(8);
		check(33'(output_enable), 33'h1);
		// Latching inhibit: a short pulse keeps the supply off
		wr(`REG_CTRL, 32'h44);
		inhibit_req <= 1'b1;
		idle(8);
		inhibit_req <= 1'b0;
		idle(8);
		check(33'(output_enable), 33'h0);
		rd(`REG_STATUS, 33'h186);
		// Function change keeps the latch
		wr(`REG_CTRL, 32'h45);
		rd(`REG_STATUS, 33'h186);
		check(33'(gpio_oe), 33'h7);
		// Port values: both extremes, then random
		for (int k = 0; k < 5; k++) begin
			val = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : 3'($urandom_range(7));
			wr(`REG_GPIO, {29'h0, val});
			idle(4);
			check(33'(gpio_o), 33'(val));
			rd(`REG_GPIO, 33'(val));
		end
		wr(`REG_CLEAR, 32'h1);
		idle(3);
		check(33'(output_enable), 33'h1);
		rd(`REG_STATUS, 33'h181);
		// Protection fault with interrupt; inhibit event stays masked
		wr(`REG_CTRL, 32'h40);
		wr(`REG_IRQ_MASK, 32'h2);
		check(33'(irq), 33'h0);
		prot_cause <= 4'h1;
		idle(3);
		check(33'(output_enable), 33'h0);
		check(33'(irq), 33'h1);
		// Clear while the cause stands must not release the supply
		wr(`REG_CLEAR, 32'h1);
		check(33'(output_enable), 33'h0);
		prot_cause <= 4'h0;
		idle(3);
		check(33'(output_enable), 33'h0);
		rd(`REG_IRQ_STAT, 33'h3);
		wr(`REG_IRQ_STAT, 32'h3);
		rd(`REG_IRQ_STAT, 33'h0);
		check(33'(irq), 33'h0);
		wr(`REG_CLEAR, 32'h1);
		idle(3);
		check(33'(output_enable), 33'h1);
		// Spare inhibit choice leaves the supply on
		wr(`REG_CTRL, 32'h46);
		inhibit_req <= 1'b1;
		idle(8);
		check(33'(output_enable), 33'h1);
		rd(`REG_STATUS, 33'h081);
		inhibit_req <= 1'b0;
		// Each fault source, selected bit alone and all others
		for (int s = 0; s < 4; s++) begin
			wr(`REG_CTRL, 32'h08 | (32'(s) << 4));
			summary <= summary_s'(4'h8 >> s);
			idle(3);
			check(33'(fault_oe), 33'h1);
			rd(`REG_STATUS, 33'h100);
			summary <= summary_s'(~(4'h8 >> s));
			idle(3);
			check(33'(fault_oe), 33'h0);
		end
		// Indicator off, then general mode, with every summary high
		summary <= summary_s'(4'hF);
		wr(`REG_CTRL, 32'h30);
		idle(3);
		check(33'(fault_oe), 33'h0);
		wr(`REG_CTRL, 32'h39);
		idle(3);
		check(33'(fault_oe), 33'h0);
		print_verdict();
	end
endmodule
